// ===== pkg/tpo_pkg.sv
`default_nettype none

package tpo_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [19:0] IDX_TRIG_SEL = 20'hfffa1;
    localparam logic [19:0] IDX_EN_HIGH = 20'hfffa2;
    localparam logic [19:0] IDX_EN_LOW = 20'hfffa3;
    localparam logic [19:0] IDX_ND_B_HI = 20'hfffa4;
    localparam logic [19:0] IDX_ND_A_HI = 20'hfffa5;
    localparam logic [19:0] IDX_ND_B_G2 = 20'hfffa6;
    localparam logic [19:0] IDX_ND_A_G0 = 20'hfffa7;
    localparam logic [19:0] IDX_PORT_A = 20'hfffd9;
    localparam logic [19:0] IDX_PORT_B = 20'hfffda;

    localparam int ADR_W = 24;
    localparam int DAT_W = 32;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    localparam int GROUPS = 4;
    localparam int CHANNELS = 3;
    localparam int SEL_W = 2;

    // values after reset and hardware standby
    localparam logic [7:0] RST_NEXT_DATA = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic [7:0] RST_TRIG_SEL = 8'hff;

    // reserved bits read as one
    localparam logic [7:0] RSVD_BYTE = 8'hff;
    localparam logic [3:0] RSVD_NIB = 4'hf;

    // trigger select field encodings
    localparam logic [1:0] SEL_CH0 = 2'b00;
    localparam logic [1:0] SEL_CH1 = 2'b01;

    typedef enum logic [3:0] {
        REG_NONE,
        REG_TRIG_SEL,
        REG_EN_HIGH,
        REG_EN_LOW,
        REG_ND_B_HI,
        REG_ND_A_HI,
        REG_ND_B_G2,
        REG_ND_A_G0,
        REG_PORT_A,
        REG_PORT_B
    } tpo_reg_t;

endpackage : tpo_pkg

`default_nettype wire

// ===== verilog/tpo_group_trigger.sv
`timescale 1ns/1ps
`default_nettype none

module tpo_group_trigger
(
    input wire logic [tpo_pkg::BYTE_W-1:0] trig_sel_i,
    input wire logic [tpo_pkg::CHANNELS-1:0] cm_match_i,
    output logic [tpo_pkg::GROUPS-1:0] fire_o,
    output logic shared_low_o,
    output logic shared_high_o
);
    import tpo_pkg::*;

    // 00 -> channel 0, 01 -> channel 1, 10 and 11 -> channel 2
    function automatic logic chan_fire(input logic [1:0] sel,
                                       input logic [2:0] cm);
        logic hit;
        if (sel == SEL_CH0)
            hit = cm[0];
        else if (sel == SEL_CH1)
            hit = cm[1];
        else
            hit = cm[2];
        return hit;
    endfunction : chan_fire

    genvar g;
    generate
        for (g = 0; g < GROUPS; g = g + 1)
        begin : g_grp
            assign fire_o[g] = chan_fire(trig_sel_i[g*SEL_W +: SEL_W],
                                         cm_match_i);
        end
    endgenerate

    // only equal fields count as a shared trigger, so 10 against 11 does not
    assign shared_low_o = trig_sel_i[1:0] == trig_sel_i[3:2];
    assign shared_high_o = trig_sel_i[5:4] == trig_sel_i[7:6];

endmodule : tpo_group_trigger

`default_nettype wire

// ===== verilog/tpo_top.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tpo_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hw_standby_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [tpo_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [tpo_pkg::DAT_W-1:0] dat_i,
    output logic [tpo_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    input wire logic [tpo_pkg::CHANNELS-1:0] cm_match_i,
    output logic [tpo_pkg::BYTE_W-1:0] pattern_a_o,
    output logic [tpo_pkg::BYTE_W-1:0] pattern_b_o
);
    import tpo_pkg::*;

    logic clear;
    logic req;
    logic wr;
    tpo_reg_t reg_sel;
    logic [7:0] wdat;
    logic [7:0] rd_byte;

    logic [7:0] trig_sel;
    logic [7:0] en_low;
    logic [7:0] en_high;
    logic [7:0] next_data_a;
    logic [7:0] next_data_b;
    logic [7:0] port_a_output_latch;
    logic [7:0] port_b_output_latch;

    logic [3:0] fire;
    logic shared_low;
    logic shared_high;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
    logic [7:0] next_nd_a;
    logic [7:0] next_nd_b;
    logic [7:0] next_port_a;
    logic [7:0] next_port_b;

    // software standby is not modelled: it simply keeps state
    assign clear = rst_i | hw_standby_i;

    tpo_group_trigger tpo_group_trigger_inst (
        .trig_sel_i(trig_sel),
        .cm_match_i(cm_match_i),
        .fire_o(fire),
        .shared_low_o(shared_low),
        .shared_high_o(shared_high)
    );

    // bus: ack one cycle after the request, writes land on the edge that ends ack
    assign req = cyc_i & stb_i;
    assign wr = req & we_i & ack_o & sel_i[0];
    assign wdat = dat_i[7:0];

    always_comb
    begin
        if (adr_i[ADR_W-1:2] == {2'b00, IDX_TRIG_SEL})
            reg_sel = REG_TRIG_SEL;
        else if (adr_i[ADR_W-1:2] == {2'b00, IDX_EN_HIGH})
            reg_sel = REG_EN_HIGH;
        else if (adr_i[ADR_W-1:2] == {2'b00, IDX_EN_LOW})
            reg_sel = REG_EN_LOW;
        else if (adr_i[ADR_W-1:2] == {2'b00, IDX_ND_B_HI})
            reg_sel = REG_ND_B_HI;
        else if (adr_i[ADR_W-1:2] == {2'b00, IDX_ND_A_HI})
            reg_sel = REG_ND_A_HI;
        else if (adr_i[ADR_W-1:2] == {2'b00, IDX_ND_B_G2})
            reg_sel = REG_ND_B_G2;
        else if (adr_i[ADR_W-1:2] == {2'b00, IDX_ND_A_G0})
            reg_sel = REG_ND_A_G0;
        else if (adr_i[ADR_W-1:2] == {2'b00, IDX_PORT_A})
            reg_sel = REG_PORT_A;
        else if (adr_i[ADR_W-1:2] == {2'b00, IDX_PORT_B})
            reg_sel = REG_PORT_B;
        else
            reg_sel = REG_NONE;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= req & ~ack_o;
    end

    // read view; layout follows the live trigger selects
    always_comb
    begin
        rd_byte = 8'h00;
        case (reg_sel)
            REG_TRIG_SEL: rd_byte = trig_sel;
            REG_EN_HIGH: rd_byte = en_high;
            REG_EN_LOW: rd_byte = en_low;
            REG_ND_A_HI:
            begin
                if (shared_low)
                    rd_byte = next_data_a;
                else
                    rd_byte = {next_data_a[7:4], RSVD_NIB};
            end
            REG_ND_A_G0:
            begin
                if (shared_low)
                    rd_byte = RSVD_BYTE;
                else
                    rd_byte = {RSVD_NIB, next_data_a[3:0]};
            end
            REG_ND_B_HI:
            begin
                if (shared_high)
                    rd_byte = next_data_b;
                else
                    rd_byte = {next_data_b[7:4], RSVD_NIB};
            end
            REG_ND_B_G2:
            begin
                if (shared_high)
                    rd_byte = RSVD_BYTE;
                else
                    rd_byte = {RSVD_NIB, next_data_b[3:0]};
            end
            REG_PORT_A: rd_byte = port_a_output_latch;
            REG_PORT_B: rd_byte = port_b_output_latch;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= '0;
        else if (req & ~ack_o)
            dat_o <= {24'h000000, rd_byte};
    end

    // trigger select, kept for the group to channel mapping
    always_ff @(posedge clk_i)
    begin
        if (clear)
            trig_sel <= RST_TRIG_SEL;
        else if (wr && reg_sel == REG_TRIG_SEL)
            trig_sel <= wdat;
    end

    always_ff @(posedge clk_i)
    begin
        if (clear)
            en_low <= RST_ENABLE;
        else if (wr && reg_sel == REG_EN_LOW)
            en_low <= wdat;
    end

    always_ff @(posedge clk_i)
    begin
        if (clear)
            en_high <= RST_ENABLE;
        else if (wr && reg_sel == REG_EN_HIGH)
            en_high <= wdat;
    end

    // next data writes; reserved nibbles never change
    always_comb
    begin
        next_nd_a = next_data_a;
        if (wr && reg_sel == REG_ND_A_HI)
        begin
            if (shared_low)
                next_nd_a = wdat;
            else
                next_nd_a[7:4] = wdat[7:4];
        end
        else if (wr && reg_sel == REG_ND_A_G0 && !shared_low)
            next_nd_a[3:0] = wdat[3:0];
    end

    always_comb
    begin
        next_nd_b = next_data_b;
        if (wr && reg_sel == REG_ND_B_HI)
        begin
            if (shared_high)
                next_nd_b = wdat;
            else
                next_nd_b[7:4] = wdat[7:4];
        end
        else if (wr && reg_sel == REG_ND_B_G2 && !shared_high)
            next_nd_b[3:0] = wdat[3:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (clear)
            next_data_a <= RST_NEXT_DATA;
        else
            next_data_a <= next_nd_a;
    end

    always_ff @(posedge clk_i)
    begin
        if (clear)
            next_data_b <= RST_NEXT_DATA;
        else
            next_data_b <= next_nd_b;
    end

    // per-bit transfer mask: group fired and pin enabled
    assign mask_a = {{4{fire[1]}}, {4{fire[0]}}} & en_low;
    assign mask_b = {{4{fire[3]}}, {4{fire[2]}}} & en_high;

    // enabled bits are owned by the pattern logic, so no write conflict
    always_comb
    begin
        next_port_a = port_a_output_latch;
        if (wr && reg_sel == REG_PORT_A)
            next_port_a = (wdat & ~en_low) |
                          (port_a_output_latch & en_low);
        next_port_a = (next_port_a & ~mask_a) |
                      (next_data_a & mask_a);
    end

    always_comb
    begin
        next_port_b = port_b_output_latch;
        if (wr && reg_sel == REG_PORT_B)
            next_port_b = (wdat & ~en_high) |
                          (port_b_output_latch & en_high);
        next_port_b = (next_port_b & ~mask_b) |
                      (next_data_b & mask_b);
    end

    always_ff @(posedge clk_i)
    begin
        if (clear)
            port_a_output_latch <= RST_PORT;
        else
            port_a_output_latch <= next_port_a;
    end

    always_ff @(posedge clk_i)
    begin
        if (clear)
            port_b_output_latch <= RST_PORT;
        else
            port_b_output_latch <= next_port_b;
    end

    // pin direction lives in the port block, not here
    assign pattern_a_o = port_a_output_latch;
    assign pattern_b_o = port_b_output_latch;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence fire_a_s;
        !clear && (|mask_a);
    endsequence

    sequence fire_b_s;
        !clear && (|mask_b);
    endsequence

    sequence bus_req_s;
        req && !ack_o && !$past(req);
    endsequence

    chk_a_copy_bits: assert property (fire_a_s |=>
        (port_a_output_latch & $past(mask_a)) ==
        ($past(next_data_a) & $past(mask_a)))
        else $error("port a did not take next data");

    chk_b_copy_bits: assert property (fire_b_s |=>
        (port_b_output_latch & $past(mask_b)) ==
        ($past(next_data_b) & $past(mask_b)))
        else $error("port b did not take next data");

    chk_a_hold_idle: assert property (
        !clear && mask_a == 8'h00 && !(wr && reg_sel == REG_PORT_A)
        |=> $stable(port_a_output_latch))
        else $error("port a changed without trigger or write");

    chk_b_ro_bits: assert property (
        !clear && wr && reg_sel == REG_PORT_B && mask_b == 8'h00
        |=> ((port_b_output_latch ^ $past(port_b_output_latch)) &
             $past(en_high)) == 8'h00)
        else $error("enabled port b bit was written");

    chk_a_ro_bits: assert property (
        !clear && wr && reg_sel == REG_PORT_A && mask_a == 8'h00
        |=> port_a_output_latch ==
            (($past(wdat) & ~$past(en_low)) |
             ($past(port_a_output_latch) & $past(en_low))))
        else $error("port a write mask wrong");

    chk_clear_values: assert property (hw_standby_i |=>
        next_data_a == RST_NEXT_DATA && next_data_b == RST_NEXT_DATA &&
        en_low == RST_ENABLE && en_high == RST_ENABLE &&
        trig_sel == RST_TRIG_SEL)
        else $error("hardware standby did not clear registers");

    chk_rsvd_read_a: assert property (
        req && !ack_o && !we_i && reg_sel == REG_ND_A_G0 && shared_low
        |=> dat_o[7:0] == RSVD_BYTE)
        else $error("reserved next data a byte not read as ones");

    chk_split_read_b: assert property (
        req && !ack_o && !we_i && reg_sel == REG_ND_B_HI && !shared_high
        |=> dat_o[7:0] == {$past(next_data_b[7:4]), RSVD_NIB})
        else $error("split next data b high byte read wrong");

    chk_rsvd_nowrite_b: assert property (
        !clear && wr && reg_sel == REG_ND_B_G2 && shared_high
        |=> $stable(next_data_b))
        else $error("reserved next data b address was written");

    // a shared layout is only safe if both groups really fire together
    chk_share_decode: assert property (
        (!shared_low || fire[0] == fire[1]) &&
        (!shared_high || fire[2] == fire[3]))
        else $error("shared layout while paired groups fire apart");

    chk_bus_ack: assert property (bus_req_s |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle after request");

endmodule : tpo_top

`default_nettype wire

// ===== verification/tpo_timer_model.sv
`timescale 1ns/1ps
`default_nettype none

module tpo_timer_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [1:0] ch_i,
    input wire logic [3:0] delay_i,
    output logic [2:0] cm_match_o
);
    logic [3:0] count;
    logic [1:0] chan;
    logic armed;

    // a delay lets the match come promptly or late
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            armed <= 1'b0;
            count <= 4'h0;
            chan <= 2'h0;
        end
        else if (go_i)
        begin
            armed <= 1'b1;
            count <= delay_i;
            chan <= ch_i;
        end
        else if (armed && count != 4'h0)
            count <= count - 4'h1;
        else
            armed <= 1'b0;
    end

    // match is one cycle wide, never stretched
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cm_match_o <= 3'h0;
        else if (armed && count == 4'h0)
            cm_match_o <= 3'h1 << chan;
        else
            cm_match_o <= 3'h0;
    end
endmodule : tpo_timer_model

`default_nettype wire

// ===== verification/tpo_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module tpo_top_bench;
    import tpo_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i, hw_standby_i, cyc_i, stb_i, we_i, ack_o, go;
    logic [23:0] adr_i;
    logic [3:0] sel_i, delay;
    logic [31:0] dat_i, dat_o;
    logic [2:0] cm_match;
    logic [1:0] ch_sel;
    logic [7:0] pattern_a_o, pattern_b_o;
    int errors = 0;
    int comparisons = 0;

    always #2 clk_i = ~clk_i;

    tpo_top tpo_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .hw_standby_i(hw_standby_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .cm_match_i(cm_match),
        .pattern_a_o(pattern_a_o), .pattern_b_o(pattern_b_o));

    tpo_timer_model tpo_timer_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .go_i(go), .ch_i(ch_sel), .delay_i(delay), .cm_match_o(cm_match));

    task print_verdict;
        if (errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one classic cycle; waits for ack without assuming its latency
    task automatic wb_cycle(input logic [19:0] idx, input logic wr,
        input logic [7:0] wdata, output logic [7:0] rdata);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        sel_i <= 4'hf;
        adr_i <= {2'h0, idx, 2'h0};
        dat_i <= {24'h0, wdata};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        rdata = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (ack_o !== 1'b1)
        begin
            errors++;
            print_verdict();
        end
    endtask : wb_cycle

    task automatic wr(input logic [19:0] idx, input logic [7:0] d);
        logic [7:0] r;
        wb_cycle(idx, 1'b1, d, r);
    endtask : wr

    task automatic rd(input string name, input logic [19:0] idx,
        input logic [7:0] exp);
        logic [7:0] r;
        wb_cycle(idx, 1'b0, 8'h00, r);
        check(name, r, exp);
    endtask : rd

    // outputs must hold through the pulse cycle and change just after it
    task automatic trig(input logic [1:0] ch, input logic [3:0] dly,
        input logic [7:0] exp_a, input logic [7:0] exp_b);
        int n;
        logic [7:0] old_a;
        logic [7:0] old_b;
        @(posedge clk_i);
        go <= 1'b1;
        ch_sel <= ch;
        delay <= dly;
        @(posedge clk_i);
        go <= 1'b0;
        old_a = pattern_a_o;
        old_b = pattern_b_o;
        n = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        while (cm_match === 3'h0 && n < 40);
        if (cm_match === 3'h0)
        begin
            errors++;
            print_verdict();
        end
        check("pin_a_hold", pattern_a_o, old_a);
        check("pin_b_hold", pattern_b_o, old_b);
        @(posedge clk_i);
        #1;
        check("pin_a", pattern_a_o, exp_a);
        check("pin_b", pattern_b_o, exp_b);
    endtask : trig

    initial
    begin
        rst_i = 1'b1;
        hw_standby_i = 1'b0;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 24'h0;
        sel_i = 4'h0;
        dat_i = 32'h0;
        go = 1'b0;
        ch_sel = 2'h0;
        delay = 4'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("trig_sel", IDX_TRIG_SEL, RST_TRIG_SEL);
        rd("nd_a", IDX_ND_A_HI, 8'h00);
        rd("nd_b", IDX_ND_B_HI, 8'h00);
        rd("en_low", IDX_EN_LOW, 8'h00);
        rd("en_high", IDX_EN_HIGH, 8'h00);
        rd("port_b", IDX_PORT_B, 8'h00);
        rd("unmapped", 20'h00010, 8'h00);
        wr(IDX_ND_A_HI, 8'ha5);
        wr(IDX_ND_A_G0, 8'h12);
        wr(IDX_ND_B_HI, 8'h3c);
        wr(IDX_ND_B_G2, 8'h12);
        rd("nd_a", IDX_ND_A_HI, 8'ha5);
        rd("nd_a_g0", IDX_ND_A_G0, 8'hff);
        rd("nd_b", IDX_ND_B_HI, 8'h3c);
        rd("nd_b_g2", IDX_ND_B_G2, 8'hff);
        wr(IDX_EN_LOW, 8'h0f);
        wr(IDX_EN_HIGH, 8'hf0);
        // pins count as driven; direction bits sit outside the block
        trig(2'h2, 4'h0, 8'h05, 8'h30);
        wr(IDX_PORT_A, 8'h00);
        wr(IDX_PORT_B, 8'hff);
        rd("port_a", IDX_PORT_A, 8'h05);
        rd("port_b", IDX_PORT_B, 8'h3f);
        check("pin_b", pattern_b_o, 8'h3f);
        // groups 0/2 on channel 0, groups 1/3 on channel 1
        wr(IDX_TRIG_SEL, 8'h44);
        rd("nd_a", IDX_ND_A_HI, 8'haf);
        rd("nd_a_g0", IDX_ND_A_G0, 8'hf5);
        rd("nd_b", IDX_ND_B_HI, 8'h3f);
        rd("nd_b_g2", IDX_ND_B_G2, 8'hfc);
        wr(IDX_ND_A_G0, 8'h3c);
        wr(IDX_ND_A_HI, 8'h96);
        wr(IDX_ND_B_G2, 8'h07);
        wr(IDX_ND_B_HI, 8'he1);
        rd("nd_a", IDX_ND_A_HI, 8'h9f);
        rd("nd_b_g2", IDX_ND_B_G2, 8'hf7);
        wr(IDX_EN_LOW, 8'hff);
        wr(IDX_EN_HIGH, 8'hff);
        trig(2'h2, 4'h5, 8'h05, 8'h3f);
        trig(2'h0, 4'h0, 8'h0c, 8'h37);
        trig(2'h1, 4'h5, 8'h9c, 8'he7);
        // 10 and 11 both pick channel 2 yet keep the split layout
        wr(IDX_TRIG_SEL, 8'hee);
        wr(IDX_ND_A_HI, 8'h5f);
        wr(IDX_ND_A_G0, 8'h0a);
        wr(IDX_ND_B_HI, 8'h2f);
        wr(IDX_ND_B_G2, 8'h01);
        rd("nd_a_g0", IDX_ND_A_G0, 8'hfa);
        trig(2'h2, 4'h0, 8'h5a, 8'h21);
        @(posedge clk_i);
        hw_standby_i <= 1'b1;
        @(posedge clk_i);
        hw_standby_i <= 1'b0;
        rd("trig_sel", IDX_TRIG_SEL, RST_TRIG_SEL);
        rd("nd_a", IDX_ND_A_HI, 8'h00);
        rd("nd_b", IDX_ND_B_HI, 8'h00);
        rd("en_low", IDX_EN_LOW, 8'h00);
        rd("en_high", IDX_EN_HIGH, 8'h00);
        check("pin_a", pattern_a_o, 8'h00);
        check("pin_b", pattern_b_o, 8'h00);
        print_verdict();
    end
endmodule : tpo_top_bench

`default_nettype wire
